// [src/uart_pkg.sv]
// Shared constants and types for the asynchronous serial channel.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package uart_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] TXH_OFS    = 8'h08;
    localparam logic [7:0] RXB_OFS    = 8'h0c;
    localparam logic [7:0] DIV_OFS    = 8'h10;
    localparam logic [7:0] SRC_OFS    = 8'h14;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] TXH_RST    = 8'hff;
    localparam logic [7:0] RXB_RST    = 8'hff;
    localparam logic [7:0] MODE_RST   = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] DIV_RST    = 8'h00;
    localparam logic [7:0] SRC_RST    = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int TXE_BIT  = 7;
    localparam int RXE_BIT  = 6;
    localparam int PS_HI    = 5;
    localparam int PS_LO    = 4;
    localparam int CL_BIT   = 3;
    localparam int SL_BIT   = 2;
    localparam int ISRM_BIT = 1;
    localparam int PE_BIT   = 2;
    localparam int FE_BIT   = 1;
    localparam int OVE_BIT  = 0;
    localparam int EXT_BIT  = 0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam logic [3:0] OVS_LAST   = 4'hf;
    localparam logic [3:0] OVS_MID    = 4'h7;
    localparam logic [2:0] BITS8_LAST = 3'h7;
    localparam logic [2:0] BITS7_LAST = 3'h6;
    localparam int CLK_HZ       = 100_000_000;
    localparam int OVS          = 16;
    localparam int MIDI_BPS     = 31_250;
    localparam int MIDI_DIVISOR = CLK_HZ / (OVS * MIDI_BPS);

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ZERO = 2'b01,
        PAR_ODD  = 2'b10,
        PAR_EVEN = 2'b11
    } parity_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_DATA   = 3'b011,
        ST_PARITY = 3'b010,
        ST_STOP   = 3'b110
    } ser_state_t;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage

// [src/sync2.sv]
// Two-stage synchroniser for levels arriving from outside pclk.
// Assumes idle-high inputs, so both stages reset to ones.
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '1;
            q        <= '1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// [src/rate_gen.sv]
// Bit-rate divider producing one oversampling tick per divisor count.
// Assumes ext_level is already synchronised to pclk.
module rate_gen #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         run,
    input  wire logic         use_ext,
    input  wire logic         ext_level,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] cnt_reg;
    logic         ext_prev_reg;
    logic         src_en;

    assign src_en = use_ext ? (ext_level & ~ext_prev_reg) : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_reg <= 1'b1;
        end else begin
            ext_prev_reg <= ext_level;
        end
    end

    // divide by divisor
    // Divisors below eight are not guarded; divisor zero counts 256 and gives the longest bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else if (!run) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else if (src_en && cnt_reg >= W'(divisor - 1'b1)) begin
            cnt_reg <= '0;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= src_en ? W'(cnt_reg + 1'b1) : cnt_reg;
            tick    <= 1'b0;
        end
    end
endmodule

// [src/async_serial_channel.sv]
// Asynchronous serial channel: APB registers, transmitter, receiver.
// Assumes an APB master on pclk and a remote station on the pins.
module async_serial_channel (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire uart_pkg::apb_req_t apb_req,
    output uart_pkg::apb_rsp_t      apb_rsp,
    input  wire logic               serial_in_pin,
    input  wire logic               ext_rate_clock_pin,
    output logic                    serial_out_pin,
    output logic                    tx_pin_serial,
    output logic                    rx_pin_serial,
    output logic                    rx_complete_irq,
    output logic                    tx_done_pulse
);
    import uart_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]  mode_reg;
    logic [7:0]  status_reg;
    logic [7:0]  txh_reg;
    logic [7:0]  rxb_reg;
    logic [7:0]  div_reg;
    logic [7:0]  src_reg;
    logic [31:0] prdata_reg;
    logic        rx_unread_reg;
    ser_state_t  tx_state_reg;
    logic [3:0]  tx_ovs_reg;
    logic [2:0]  tx_bit_reg;
    logic [7:0]  tx_shift_reg;
    logic        tx_par_reg;
    logic        tx_stop2_reg;
    logic        tx_line_next;
    ser_state_t  rx_state_reg;
    logic [3:0]  rx_ovs_reg;
    logic [2:0]  rx_bit_reg;
    logic [7:0]  rx_shift_reg;
    logic        rx_par_reg;
    logic        rx_s;
    logic        ext_s;
    logic        tick;
    logic        setup;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic        tx_en;
    logic        rx_en;
    logic        len8;
    parity_t     par_mode;
    logic [2:0]  last_bit;
    logic        tx_start;
    logic [7:0]  tx_data;
    logic        rx_done;
    logic [7:0]  rx_data;
    logic        pe_now;
    logic        fe_now;
    logic        err_now;

    // ----------------------------------------------------------------
    // Pin synchronisers and rate generator
    // ----------------------------------------------------------------
    sync2 #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({serial_in_pin, ext_rate_clock_pin}),
        .q       ({rx_s, ext_s})
    );

    rate_gen #(.W(8)) u_rate (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (tx_en | rx_en),
        .use_ext   (src_reg[EXT_BIT]),
        .ext_level (ext_s),
        .divisor   (div_reg),
        .tick      (tick)
    );

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    assign tx_en    = mode_reg[TXE_BIT];
    assign rx_en    = mode_reg[RXE_BIT];
    assign len8     = mode_reg[CL_BIT];
    assign par_mode = parity_t'(mode_reg[PS_HI:PS_LO]);
    assign last_bit = len8 ? BITS8_LAST : BITS7_LAST;
    // Masked from the bus word: the holding register lands at that edge.
    assign tx_data  = len8 ? apb_req.pwdata[7:0] :
                      {1'b0, apb_req.pwdata[6:0]};

    assign tx_pin_serial = tx_en;
    assign rx_pin_serial = rx_en;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign setup  = apb_req.psel & ~apb_req.penable;
    assign wr     = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd     = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
    assign mapped = apb_req.paddr inside {MODE_OFS, STATUS_OFS,
                    TXH_OFS, RXB_OFS, DIV_OFS, SRC_OFS};

    // Read data is captured in the setup cycle so that prdata comes
    // from a flip-flop while pready can stay high with no wait.
    assign apb_rsp.prdata  = prdata_reg;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            case (apb_req.paddr)
                MODE_OFS:   prdata_reg <= {24'h00_0000, mode_reg};
                STATUS_OFS: prdata_reg <= {24'h00_0000, status_reg};
                RXB_OFS:    prdata_reg <= {24'h00_0000, rxb_reg};
                DIV_OFS:    prdata_reg <= {24'h00_0000, div_reg};
                SRC_OFS:    prdata_reg <= {24'h00_0000, src_reg};
                default:    prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= MODE_RST;
        end else if (wr && apb_req.paddr == MODE_OFS &&
                     apb_req.pstrb[0]) begin
            // Bit zero is reserved and always kept low.
            mode_reg <= {apb_req.pwdata[7:1], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= DIV_RST;
            src_reg <= SRC_RST;
        end else if (wr && apb_req.pstrb[0]) begin
            if (apb_req.paddr == DIV_OFS) begin
                div_reg <= apb_req.pwdata[7:0];
            end
            if (apb_req.paddr == SRC_OFS) begin
                src_reg <= {7'h00, apb_req.pwdata[EXT_BIT]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txh_reg <= TXH_RST;
        end else if (wr && apb_req.paddr == TXH_OFS &&
                     apb_req.pstrb[0]) begin
            txh_reg <= apb_req.pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    // write launches frame
    // A write during a frame restarts it; software must not do that.
    assign tx_start = wr && apb_req.paddr == TXH_OFS &&
                      apb_req.pstrb[0] && tx_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= ST_IDLE;
            tx_ovs_reg   <= 4'h0;
            tx_bit_reg   <= 3'h0;
            tx_shift_reg <= 8'hff;
            tx_par_reg   <= 1'b0;
            tx_stop2_reg <= 1'b0;
        end else if (!tx_en) begin
            tx_state_reg <= ST_IDLE;
            tx_ovs_reg   <= 4'h0;
        end else if (tx_start) begin
            tx_state_reg <= ST_START;
            tx_ovs_reg   <= 4'h0;
            tx_bit_reg   <= 3'h0;
            tx_shift_reg <= tx_data;
            case (par_mode)
                PAR_ODD:  tx_par_reg <= ~^tx_data;
                PAR_EVEN: tx_par_reg <= ^tx_data;
                default:  tx_par_reg <= 1'b0;
            endcase
            tx_stop2_reg <= mode_reg[SL_BIT];
        end else if (tick) begin
            tx_ovs_reg <= 4'(tx_ovs_reg + 1'b1);
            if (tx_ovs_reg == OVS_LAST) begin
                case (tx_state_reg)
                    ST_START: begin
                        tx_state_reg <= ST_DATA;
                    end
                    ST_DATA: begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
                        tx_bit_reg   <= 3'(tx_bit_reg + 1'b1);
                        if (tx_bit_reg == last_bit) begin
                            tx_state_reg <= (par_mode == PAR_NONE) ?
                                            ST_STOP : ST_PARITY;
                        end
                    end
                    ST_PARITY: begin
                        tx_state_reg <= ST_STOP;
                    end
                    ST_STOP: begin
                        tx_stop2_reg <= 1'b0;
                        if (!tx_stop2_reg) begin
                            tx_state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        tx_state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_comb begin
        case (tx_state_reg)
            ST_START:  tx_line_next = 1'b0;
            ST_DATA:   tx_line_next = tx_shift_reg[0];
            ST_PARITY: tx_line_next = tx_par_reg;
            default:   tx_line_next = 1'b1;
        endcase
        if (tx_start) begin
            tx_line_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin <= 1'b1;
            tx_done_pulse  <= 1'b0;
        end else begin
            serial_out_pin <= tx_line_next;
            tx_done_pulse  <= tx_en && !tx_start && tick &&
                              tx_state_reg == ST_STOP &&
                              tx_ovs_reg == OVS_LAST && !tx_stop2_reg;
        end
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    // independent of transmitter
    // mid-bit sampling
    // After the start bit is confirmed at its middle, every later
    // sample falls sixteen ticks on, at the middle of each bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_reg <= ST_IDLE;
            rx_ovs_reg   <= 4'h0;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_par_reg   <= 1'b0;
        end else if (!rx_en) begin
            rx_state_reg <= ST_IDLE;
            rx_ovs_reg   <= 4'h0;
        end else begin
            case (rx_state_reg)
                ST_IDLE: begin
                    rx_ovs_reg <= 4'h0;
                    rx_bit_reg <= 3'h0;
                    if (!rx_s) begin
                        rx_state_reg <= ST_START;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        rx_ovs_reg <= 4'(rx_ovs_reg + 1'b1);
                        if (rx_ovs_reg == OVS_MID) begin
                            rx_ovs_reg   <= 4'h0;
                            rx_state_reg <= rx_s ? ST_IDLE : ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (tick) begin
                        rx_ovs_reg <= 4'(rx_ovs_reg + 1'b1);
                        if (rx_ovs_reg == OVS_LAST) begin
                            rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
                            rx_bit_reg   <= 3'(rx_bit_reg + 1'b1);
                            if (rx_bit_reg == last_bit) begin
                                rx_state_reg <= (par_mode == PAR_NONE) ?
                                                ST_STOP : ST_PARITY;
                            end
                        end
                    end
                end
                ST_PARITY: begin
                    if (tick) begin
                        rx_ovs_reg <= 4'(rx_ovs_reg + 1'b1);
                        if (rx_ovs_reg == OVS_LAST) begin
                            rx_par_reg   <= rx_s;
                            rx_state_reg <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        rx_ovs_reg <= 4'(rx_ovs_reg + 1'b1);
                        if (rx_ovs_reg == OVS_LAST) begin
                            rx_state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    rx_state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign rx_done = rx_en && tick && rx_state_reg == ST_STOP &&
                     rx_ovs_reg == OVS_LAST;

    assign rx_data = len8 ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};

    // error checks
    // Zero parity is sent but never checked on receive.
    always_comb begin
        case (par_mode)
            PAR_ODD:  pe_now = ~(^rx_data ^ rx_par_reg);
            PAR_EVEN: pe_now = ^rx_data ^ rx_par_reg;
            default:  pe_now = 1'b0;
        endcase
    end
    assign fe_now  = ~rx_s;
    assign err_now = pe_now | fe_now | rx_unread_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxb_reg <= RXB_RST;
        end else if (rx_done) begin
            rxb_reg <= rx_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= STATUS_RST;
        end else if (rx_done) begin
            status_reg <= {5'h00, pe_now, fe_now, rx_unread_reg};
        end
    end

    // A completion in the same cycle as a buffer read keeps it unread.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_unread_reg <= 1'b0;
        end else if (rx_done) begin
            rx_unread_reg <= 1'b1;
        end else if (rd && apb_req.paddr == RXB_OFS) begin
            rx_unread_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_complete_irq <= 1'b0;
        end else begin
            rx_complete_irq <= rx_done &&
                               !(mode_reg[ISRM_BIT] && err_now);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TX_LAUNCH: assert property (
        tx_start |=> !serial_out_pin && tx_state_reg == ST_START)
        else $error("transmit write did not start a frame");
    AST_TX_IDLE_HIGH: assert property (
        tx_state_reg == ST_IDLE && !tx_start |=> serial_out_pin)
        else $error("idle transmit line not high");
    AST_TX_STOP_HIGH: assert property (
        tx_state_reg == ST_STOP |=> serial_out_pin)
        else $error("stop bit not high");
    AST_TX_ZERO_PAR: assert property (
        tx_state_reg == ST_PARITY && par_mode == PAR_ZERO
        |=> !serial_out_pin)
        else $error("zero parity bit not low");
    AST_RX_SEVEN: assert property (
        rx_done && !len8 |=> rxb_reg[7] == 1'b0)
        else $error("seven-bit character has top bit set");
    AST_RX_NO_WRITE: assert property (
        wr && apb_req.paddr == RXB_OFS && !rx_done |=> $stable(rxb_reg))
        else $error("receive buffer changed by a write");
    AST_MODE_WRITE: assert property (
        wr && apb_req.paddr == MODE_OFS && apb_req.pstrb[0]
        |=> mode_reg[7:1] == $past(apb_req.pwdata[7:1]) && !mode_reg[0])
        else $error("mode register write not taken");
    AST_OVERRUN: assert property (
        rx_done && rx_unread_reg |=> status_reg[OVE_BIT] && rx_unread_reg)
        else $error("overrun not flagged");
    AST_IRQ_MASK: assert property (
        rx_complete_irq |-> $past(rx_done) &&
        !($past(mode_reg[ISRM_BIT]) && $past(err_now)))
        else $error("receive interrupt despite suppression");
    AST_STOPPED: assert property (
        !tx_en && !rx_en |=> tx_state_reg == ST_IDLE &&
        rx_state_reg == ST_IDLE && !tick)
        else $error("transfers active in stopped mode");
endmodule

// [tb/remote_station.sv]
// Remote serial station: sends frames, decodes eight-bit frames.
// Assumes a fixed bit time matching the channel's divisor setting.
module remote_station #(
    parameter int BIT_NS = 1280
) (
    input  wire logic  rx_line,
    output logic       tx_line,
    output logic [7:0] rx_byte,
    output logic       rx_stop
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tx_line = 1'b1;
        rx_byte = 8'h00;
        rx_stop = 1'b0;
    end
    task automatic send(input logic [11:0] frame, input int n);
        for (int i = 0; i < n; i++) begin
            tx_line = frame[i];
            #(BIT_NS);
        end
        tx_line = 1'b1;
    endtask
    always @(negedge rx_line) begin
        rx_stop = 1'b0;
        #(BIT_NS * 3 / 2);
        for (int i = 0; i < 8; i++) begin
            rx_byte[i] = rx_line;
            #(BIT_NS);
        end
        rx_stop = rx_line;
    end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the serial channel over APB.
// Assumes divisor 8, so one bit lasts 128 pclk cycles.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import uart_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, tx_ser, rx_ser, irq, txd, sout;
    logic ext = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    wire logic sin;
    int err_total = 0, cmp_count = 0, irq_cnt = 0;
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    async_serial_channel dut (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .serial_in_pin(sin),
        .ext_rate_clock_pin(ext), .serial_out_pin(sout),
        .tx_pin_serial(tx_ser), .rx_pin_serial(rx_ser),
        .rx_complete_irq(irq), .tx_done_pulse(txd));
    remote_station peer (.rx_line(sout), .tx_line(sin), .rx_byte(),
        .rx_stop());
    task automatic conclude();
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic waitfor(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) begin
            err_total++;
            conclude();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [32:0] q);
        int n;
        @(posedge pclk);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.pstrb <= 4'h1;
        req.psel <= 1'b1;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 3000);
        if (rsp.pready !== 1'b1) begin
            err_total++;
            conclude();
        end
        q = {rsp.pslverr, rsp.prdata};
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [32:0] e);
        logic [32:0] q;
        apb(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(MODE_OFS, {1'b0, 24'h0, MODE_RST});
        rdc(STATUS_OFS, {1'b0, 24'h0, STATUS_RST});
        rdc(RXB_OFS, {1'b0, 24'h0, RXB_RST});
        rdc(TXH_OFS, 33'h0);
        wr(RXB_OFS, 32'h0);
        rdc(RXB_OFS, 33'h0ff);
        rdc(8'h18, 33'h100000000);
        wr(DIV_OFS, 32'h8);
        wr(MODE_OFS, 32'hc8);
        @(posedge pclk);
        chk("pins", 33'h3, {31'h0, tx_ser, rx_ser});
        wr(TXH_OFS, 32'ha5);
        waitfor(txd);
        chk("tx byte", 33'h1a5, {24'h0, peer.rx_stop, peer.rx_byte});
        fork
            peer.send(12'h278, 10);
            waitfor(irq);
        join
        rdc(RXB_OFS, 33'h3c);
        rdc(STATUS_OFS, 33'h0);
        wr(MODE_OFS, 32'he2);
        peer.send(12'h2aa, 10);
        repeat (40) @(posedge pclk);
        rdc(RXB_OFS, 33'h55);
        rdc(STATUS_OFS, 33'h4);
        chk("irq count", 33'h1, 33'(irq_cnt));
        wr(SRC_OFS, 32'h1);
        wr(TXH_OFS, 32'hff);
        for (int i = 0; i < 140; i++) begin
            if (i == 100) chk("ext start", 33'h0, {32'h0, sout});
            ext <= 1'b1;
            repeat (2) @(posedge pclk);
            ext <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        chk("ext data", 33'h1, {32'h0, sout});
        wr(MODE_OFS, 32'h0);
        @(posedge pclk);
        chk("pins off", 33'h0, {31'h0, tx_ser, rx_ser});
        conclude();
    end
endmodule
